// File: hw/frt_core.v
// Over-temperature fault response: delay, retry and latched shutdown.
// Assumes fault and command inputs come from pins outside this clock.
//
// Behaviour
// (RULE1) Retry code 101 allows five restart attempts.
// (RULE2) Retry code 110 allows six restart attempts.
// (RULE3) Exhausted retries latch output off until cleared.
// (RULE4) Code 111 retries forever until stopped.
// (RULE5) Three-bit delay counts time units.
// (RULE6) Spacing runs from attempt start to next.
// (RULE7) Time unit length comes from separate register.
// (RULE8) Delay codes 3..6 give 8..64 units.
// (RULE9) Response 00 ignores the fault entirely.
// (RULE10) Response 01 runs for delay, then retries.
// (RULE11) Response 10 disables at once, then retries.
// (RULE12) Retry code 000 never restarts, stays latched.
// (RULE13) Codes 0,1,2,7 give 1,2,4,128 units.
//
// The implementer's own choices: strobed register access and the register addresses.
`include "frt_map.vh"
`default_nettype none

module frt_core (
  // Clock and reset.
  input wire core_clk_i,
  input wire sys_rst_i,
  // Register port.
  input wire [7:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  // Converter pins.
  input wire ot_fault_i,
  input wire run_cmd_i,
  input wire other_fault_i,
  // Converter control.
  output reg power_en_o,
  output reg fault_latched_o,
  output reg retrying_o
);

  // Control states.
  localparam ST_OFF = 3'h0;
  localparam ST_RUN = 3'h1;
  localparam ST_DELAY = 3'h2;
  localparam ST_RETRY = 3'h3;
  localparam ST_LATCH = 3'h4;

  // Delay code to number of time units, doubling per step.
  function [7:0] delay_units;
    input [2:0] code;
    begin
      delay_units = 8'h01 << code; // RULE8 RULE13
    end
  endfunction

  // Retry code to attempt limit; code 111 never reaches it.
  function [2:0] retry_limit;
    input [2:0] code;
    begin
      retry_limit = code; // RULE1 RULE2
    end
  endfunction

  reg [7:0] resp_q;
  reg [15:0] unit_q;
  reg [1:0] fault_s_q;
  reg [1:0] run_s_q;
  reg [1:0] other_s_q;
  reg run_prev_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [2:0] count_q;
  reg [2:0] count_d;
  reg tmr_start;
  reg tmr_stop;
  wire tmr_done;
  wire fault_w;
  wire run_w;
  wire other_w;
  wire clear_wr;
  wire run_rise;
  wire [1:0] resp_w;
  wire [2:0] retry_w;
  wire [2:0] delay_w;

  assign fault_w = fault_s_q[1];
  assign run_w = run_s_q[1];
  assign other_w = other_s_q[1];
  assign resp_w = resp_q[`FRT_RESP_HI:`FRT_RESP_LO];
  assign retry_w = resp_q[`FRT_RETRY_HI:`FRT_RETRY_LO];
  assign delay_w = resp_q[`FRT_DELAY_HI:`FRT_DELAY_LO]; // RULE5
  assign clear_wr = reg_wr_i && (reg_addr_i == `FRT_ADDR_CONTROL) &&
                    reg_wdata_i[`FRT_CTRL_CLEAR];
  assign run_rise = run_w && !run_prev_q;

  // Two-stage synchronisers for the pin inputs.
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fault_s_q <= 2'h0;
      run_s_q <= 2'h0;
      other_s_q <= 2'h0;
      run_prev_q <= 1'b0;
    end else begin
      fault_s_q <= {fault_s_q[0], ot_fault_i};
      run_s_q <= {run_s_q[0], run_cmd_i};
      other_s_q <= {other_s_q[0], other_fault_i};
      run_prev_q <= run_w;
    end
  end

  // Register writes; the unit length lives apart from the response.
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      resp_q <= `FRT_RESPONSE_RST;
      unit_q <= `FRT_UNIT_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `FRT_ADDR_RESPONSE) begin
        resp_q <= reg_wdata_i[7:0];
      end
      if (reg_addr_i == `FRT_ADDR_UNIT) begin
        unit_q <= reg_wdata_i; // RULE7
      end
    end
  end

  // Register reads answer in the next cycle only; unmapped reads give 0.
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `FRT_ADDR_RESPONSE: reg_rdata_o <= {8'h00, resp_q};
        `FRT_ADDR_UNIT: reg_rdata_o <= unit_q;
        `FRT_ADDR_STATUS: reg_rdata_o <= {5'h00, fault_latched_o,
                                          power_en_o, fault_w, 2'h0,
                                          count_q, state_q};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // Next state. Off commands and other faults override everything and
  // also clear a latched fault; a clear write in the same cycle as a
  // latching event loses to the event.
  always @* begin
    state_d = state_q;
    count_d = count_q;
    tmr_start = 1'b0;
    tmr_stop = 1'b0;
    if (!run_w || other_w) begin
      state_d = ST_OFF; // RULE4
      count_d = 3'h0;
      tmr_stop = 1'b1;
    end else begin
      case (state_q)
        ST_OFF: begin
          if (run_rise || !fault_w || resp_w == `FRT_RESP_IGNORE) begin
            state_d = ST_RUN;
          end
        end
        ST_RUN: begin
          if (fault_w) begin
            case (resp_w)
              `FRT_RESP_IGNORE: state_d = ST_RUN; // RULE9
              `FRT_RESP_DELAY: begin
                state_d = ST_DELAY; // RULE10
                tmr_start = 1'b1;
              end
              `FRT_RESP_DISABLE: begin
                if (retry_w == `FRT_RETRY_NONE) begin
                  state_d = ST_LATCH; // RULE12
                end else begin
                  state_d = ST_RETRY; // RULE11
                  tmr_start = 1'b1;
                end
              end
              default: state_d = ST_LATCH;
            endcase
          end
        end
        ST_DELAY: begin
          if (!fault_w) begin
            state_d = ST_RUN;
            tmr_stop = 1'b1;
          end else if (tmr_done) begin
            if (retry_w == `FRT_RETRY_NONE) begin
              state_d = ST_LATCH; // RULE12
            end else begin
              state_d = ST_RETRY; // RULE10
              tmr_start = 1'b1;
            end
          end
        end
        ST_RETRY: begin
          if (tmr_done) begin
            count_d = count_q + 3'h1;
            if (!fault_w) begin
              state_d = ST_RUN;
              count_d = 3'h0;
            end else if (retry_w != `FRT_RETRY_FOREVER &&
                         count_q + 3'h1 >= retry_limit(retry_w)) begin
              state_d = ST_LATCH; // RULE1 RULE2 RULE3
            end else begin
              tmr_start = 1'b1; // RULE6
              if (retry_w == `FRT_RETRY_FOREVER) begin
                count_d = 3'h0; // RULE4
              end
            end
          end
        end
        ST_LATCH: begin
          if (clear_wr || run_rise) begin
            state_d = ST_RUN; // RULE3
            count_d = 3'h0;
          end
        end
        default: state_d = ST_OFF;
      endcase
    end
  end

  // State and output flops.
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ST_OFF;
      count_q <= 3'h0;
      power_en_o <= 1'b0;
      fault_latched_o <= 1'b0;
      retrying_o <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      power_en_o <= (state_d == ST_RUN) || (state_d == ST_DELAY);
      fault_latched_o <= (state_d == ST_LATCH); // RULE3
      retrying_o <= (state_d == ST_RETRY);
    end
  end

  // Delay and spacing timer.
  frt_timer u_timer (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(tmr_start),
    .stop_i(tmr_stop),
    .units_i(delay_units(delay_w)),
    .unit_cycles_i(unit_q),
    .done_o(tmr_done),
    .busy_o()
  );

endmodule

`default_nettype wire

// File: hw/frt_map.vh
// Constants for the over-temperature fault retry policy block.
// Assumes it is included by its bare name from the design files.
`ifndef FRT_MAP_VH
`define FRT_MAP_VH

// Register byte addresses on the plain register port.
`define FRT_ADDR_RESPONSE 8'h00
`define FRT_ADDR_UNIT 8'h04
`define FRT_ADDR_CONTROL 8'h08
`define FRT_ADDR_STATUS 8'h0c

// Fault response setting fields.
`define FRT_RESP_HI 7
`define FRT_RESP_LO 6
`define FRT_RETRY_HI 5
`define FRT_RETRY_LO 3
`define FRT_DELAY_HI 2
`define FRT_DELAY_LO 0
`define FRT_RESPONSE_RST 8'h80

// Response codes.
`define FRT_RESP_IGNORE 2'h0
`define FRT_RESP_DELAY 2'h1
`define FRT_RESP_DISABLE 2'h2
`define FRT_RESP_LATCH 2'h3

// Retry codes with their own meaning.
`define FRT_RETRY_NONE 3'h0
`define FRT_RETRY_FIVE 3'h5
`define FRT_RETRY_SIX 3'h6
`define FRT_RETRY_FOREVER 3'h7

// Control register: write one to clear a latched fault.
`define FRT_CTRL_CLEAR 0

// Status register fields.
`define FRT_STAT_STATE_HI 2
`define FRT_STAT_STATE_LO 0
`define FRT_STAT_COUNT_HI 5
`define FRT_STAT_COUNT_LO 3
`define FRT_STAT_FAULT 8
`define FRT_STAT_POWER 9
`define FRT_STAT_LATCH 10

// Default length of one delay time unit: 1 ms of 25 MHz clocks.
`define FRT_UNIT_RST 16'h61a8

`endif

// File: hw/frt_timer.v
// Delay timer: counts a number of time units, each a number of clocks.
// Assumes start is a one-cycle pulse from logic on the same clock.
`default_nettype none

module frt_timer (
  // Clock and reset.
  input wire core_clk_i,
  input wire sys_rst_i,
  // Control.
  input wire start_i,
  input wire stop_i,
  input wire [7:0] units_i,
  input wire [15:0] unit_cycles_i,
  // Result.
  output reg done_o,
  output wire busy_o
);

  reg [15:0] pre_q;
  reg [7:0] units_q;
  reg run_q;

  assign busy_o = run_q;

  // Prescaler marks each time unit; the unit counter ends the delay.
  // A start while running restarts the measurement from this cycle.
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_q <= 16'h0000;
      units_q <= 8'h00;
      run_q <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (stop_i) begin
        run_q <= 1'b0;
      end else if (start_i) begin
        run_q <= 1'b1;
        pre_q <= 16'h0001;
        units_q <= units_i;
      end else if (run_q) begin
        if (pre_q >= unit_cycles_i) begin
          pre_q <= 16'h0001;
          if (units_q <= 8'h01) begin
            run_q <= 1'b0;
            done_o <= 1'b1;
          end else begin
            units_q <= units_q - 8'h01;
          end
        end else begin
          pre_q <= pre_q + 16'h0001;
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: bench/frt_core_properties.sv
// Checker for the fault retry block, bound to its top ports.
// Assumes one clock domain and the unit register set small.
`default_nettype none
module frt_props (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // Pins.
  input wire logic ot_fault_i,
  input wire logic run_cmd_i,
  input wire logic other_fault_i,
  input wire logic power_en_o,
  input wire logic fault_latched_o,
  input wire logic retrying_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] resp_q;
  logic [2:0] calm_q;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Mirror the response field and count quiet cycles of the pins.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      resp_q <= 2'h2;
      calm_q <= 3'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == 8'h00) resp_q <= reg_wdata_i[7:6];
      if (!run_cmd_i || other_fault_i) calm_q <= 3'h0;
      else if (calm_q != 3'h7) calm_q <= calm_q + 3'h1;
    end
  end
  property p_lat; fault_latched_o |-> !power_en_o; endproperty
  a_lat: assert property (p_lat) else $error("power while latched");
  property p_hold;
    fault_latched_o && calm_q == 3'h7 && !reg_wr_i |=> fault_latched_o;
  endproperty
  a_hold: assert property (p_hold) else $error("latch lost");
  property p_rty; retrying_o |-> !power_en_o && !fault_latched_o; endproperty
  a_rty: assert property (p_rty) else $error("power in spacing");
  property p_dis;
    resp_q == 2'h2 && power_en_o && ot_fault_i |-> ##[1:5] !power_en_o;
  endproperty
  a_dis: assert property (p_dis) else $error("no disable");
  property p_ign;
    resp_q == 2'h0 && power_en_o && calm_q == 3'h7 |=> power_en_o;
  endproperty
  a_ign: assert property (p_ign) else $error("fault not ignored");
  property p_oth; other_fault_i |-> ##[1:5] !power_en_o; endproperty
  a_oth: assert property (p_oth) else $error("other fault ignored");
  property p_off;
    !run_cmd_i |-> ##[1:5] (!power_en_o && !fault_latched_o);
  endproperty
  a_off: assert property (p_off) else $error("off ignored");
  property p_rd0; !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000; endproperty
  a_rd0: assert property (p_rd0) else $error("stray read data");
  c_lat: cover property ($rose(fault_latched_o));
  c_rty: cover property ($rose(retrying_o));
  c_on: cover property ($rose(power_en_o));
endmodule
`default_nettype wire

// File: bench/frt_host.sv
// Host model: a plain register bus master for the fault retry block.
// Assumes read data stand only in the cycle after the read strobe.
`default_nettype none
module frt_host (
  // Clock.
  input wire logic clk_i,
  // Register port.
  output var logic [7:0] addr_o,
  output var logic [15:0] wdata_o,
  output var logic wr_o,
  output var logic rd_o,
  input wire logic [15:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero.
  initial begin
    addr_o = 8'hff;
    wdata_o = 16'hffff;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // One write cycle; released lines carry inverted values.
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // One read cycle; data are taken at the edge that ends their cycle.
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Top testbench for the fault retry block.
// Assumes the host model drives the register port.
`include "frt_map.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic flt = 1'b0;
  logic run = 1'b0;
  logic oth = 1'b0;
  logic [7:0] addr;
  logic [15:0] wdata, rdata;
  logic wr, rd, pwr, lat, rty;
  int failures = 0;
  int check_count = 0;
  int t0, t1;
  // Clock at 25 MHz.
  initial forever #20 clk = ~clk;
  frt_core DUT (.core_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .ot_fault_i(flt), .run_cmd_i(run), .other_fault_i(oth),
    .power_en_o(pwr), .fault_latched_o(lat), .retrying_o(rty));
  frt_host host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .rdata_i(rdata));
  // Word and bit comparisons.
  task chk(input logic [15:0] g, input logic [15:0] e, input string m);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task cb(input logic g, input logic e, input string m);
    chk({15'h0, g}, {15'h0, e}, m);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Wait, bounded, for the latch flag or the power enable to reach v.
  task wt(input bit w, input logic v, output int n);
    n = 0;
    while ((w ? lat : pwr) !== v && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (n >= 600) begin
      failures++;
      $display("[FAIL] %0t wait ran out", $time);
    end
  endtask
  // Turn the converter off, then on with no fault present.
  task go_on;
    run <= 1'b0;
    flt <= 1'b0;
    cyc(8);
    run <= 1'b1;
    cyc(8);
    cb(pwr, 1'b1, "no power");
  endtask
  task t_regs;
    logic [15:0] d;
    host.rd(`FRT_ADDR_RESPONSE, d);
    chk(d, 16'h0080, "response reset");
    host.rd(`FRT_ADDR_UNIT, d);
    chk(d, 16'h61a8, "unit reset");
    host.rd(8'h20, d);
    chk(d, 16'h0000, "unmapped");
    host.wr(`FRT_ADDR_UNIT, 16'h0002);
    $display("regs done");
  endtask
  task t_retry(input logic [2:0] c, input logic [2:0] dl, output int t);
    logic [15:0] d;
    host.wr(`FRT_ADDR_RESPONSE, {10'h2, c, dl});
    go_on;
    flt <= 1'b1;
    wt(1'b1, 1'b1, t);
    host.rd(`FRT_ADDR_STATUS, d);
    chk({12'h0, d[9], d[5:3]}, {13'h0, c}, "attempts");
    flt <= 1'b0;
    cyc(20);
    cb(lat, 1'b1, "latch dropped");
    host.wr(`FRT_ADDR_CONTROL, 16'h0001);
    cyc(2);
    cb(lat, 1'b0, "clear ignored");
    $display("retry done");
  endtask
  // Response 11 shuts the output at once and never retries.
  task t_latch;
    logic [15:0] d;
    int n;
    host.wr(`FRT_ADDR_RESPONSE, 16'h00e8);
    go_on;
    flt <= 1'b1;
    wt(1'b1, 1'b1, n);
    host.rd(`FRT_ADDR_STATUS, d);
    chk(d, 16'h0504, "latch status");
    flt <= 1'b0;
    $display("latch done");
  endtask
  task t_delay;
    int n, b;
    for (int c = 0; c < 8; c++) begin
      host.wr(`FRT_ADDR_RESPONSE, {13'h8, 3'(c)});
      go_on;
      flt <= 1'b1;
      wt(1'b0, 1'b0, n);
      if (c == 0) b = n;
      chk(16'(n - b), 16'(((1 << c) - 1) * 2), "delay");
    end
    $display("delay done");
  endtask
  task t_forever;
    host.wr(`FRT_ADDR_RESPONSE, 16'h00b8);
    go_on;
    flt <= 1'b1;
    cyc(100);
    cb(lat, 1'b0, "gave up");
    cb(rty, 1'b1, "not retrying");
    oth <= 1'b1;
    cyc(8);
    cb(pwr | rty, 1'b0, "not stopped");
    oth <= 1'b0;
    $display("forever done");
  endtask
  task t_ignore;
    host.wr(`FRT_ADDR_RESPONSE, 16'h0028);
    go_on;
    flt <= 1'b1;
    cyc(50);
    cb(pwr, 1'b1, "fault not ignored");
    flt <= 1'b0;
    $display("ignore done");
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    cyc(12);
    rst <= 1'b0;
    t_regs;
    t_retry(3'h5, 3'h0, t0);
    t_retry(3'h5, 3'h1, t1);
    chk(16'(t1 - t0), 16'h000a, "spacing");
    t_retry(3'h6, 3'h0, t0);
    t_retry(3'h0, 3'h0, t0);
    t_latch;
    t_delay;
    t_forever;
    t_ignore;
    report_and_stop;
  end
  // Cut a hang short far beyond the expected run length.
  initial begin
    cyc(20000);
    failures++;
    report_and_stop;
  end
endmodule
bind frt_core frt_props u_props (.core_clk_i(core_clk_i),
  .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .ot_fault_i(ot_fault_i), .run_cmd_i(run_cmd_i),
  .other_fault_i(other_fault_i), .power_en_o(power_en_o),
  .fault_latched_o(fault_latched_o), .retrying_o(retrying_o));
`default_nettype wire
